//--- hw/irs_restart.sv
`timescale 1ns/100ps
`include "irs_map.svh"
// Operation
// - released clock stops the baud counter until the clock reads high
// - clock seen high reloads counter, high phase lasts a full period
// - restart begins only when requested while the master is idle
// - restart pulls clock low, then loads counter once clock reads low
// - data line released high one baud period before clock is released
// - timeout with data high releases clock; clock high reloads counter
// - data and clock held high one full baud period before start
// - data driven low one baud period while clock stays high
// - request bit clears itself; no reload and data stays low
// - start-seen flag sets as soon as start is seen on the lines
// - event flag raised only after counter times out past start
// - restart request during another bus event has no effect
// - collision if data reads low as clock rises
// - collision if clock falls before we drive data low
// - buffer write during restart sets write collision, keeps buffer
// - low five control bits are write-blocked until restart completes
module irs_restart
  import irs_pkg::*;
(
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_ce,
  input  wire logic                       i_scl,
  input  wire logic                       i_sda,
  input  wire logic                       i_other_busy,
  input  wire logic [`IRS_RELOAD_W-1:0]   i_baud_reload_value,
  input  wire logic                       i_ctl2_we,
  input  wire logic [`IRS_CTL2_LOW_W-1:0] i_ctl2_wdata,
  input  wire logic                       i_buf_we,
  input  wire logic [`IRS_DATA_W-1:0]     i_buf_wdata,
  input  wire logic                       i_evt_clr,
  input  wire logic                       i_write_collision_flag_clr,
  input  wire logic                       i_bcol_clr,
  output logic                            o_scl_o,
  output logic                            o_scl_oe,
  output logic                            o_sda_o,
  output logic                            o_sda_oe,
  output logic [`IRS_CTL2_LOW_W-1:0]      o_serial_port_control_2,
  output logic                            o_start_seen,
  output logic                            o_port_event_flag,
  output logic                            o_write_collision_flag,
  output logic                            o_bus_collision_flag,
  output logic [`IRS_DATA_W-1:0]          o_shift_buffer
);
  import irs_pkg::*;

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  irs_lines_t meta_ff;
  irs_lines_t sync_ff;
  irs_lines_t prev_ff;

  // first stage feeds only the second one
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_ff <= '1;
      sync_ff <= '1;
      prev_ff <= '1;
    end else if (i_ce) begin
      meta_ff <= '{scl: i_scl, sda: i_sda};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  logic scl_rise;
  logic start_cond;
  assign scl_rise   = sync_ff.scl && !prev_ff.scl;
  assign start_cond = prev_ff.sda && !sync_ff.sda && sync_ff.scl;

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  irs_state_t state_ff;
  irs_state_t nxt_state;
  logic       tmo;
  logic       brg_load;
  logic       brg_run;
  logic       restart_bit;
  logic       busy;
  logic       bcol_hit;

  assign restart_bit = o_serial_port_control_2[`IRS_CTL2_RESTART_BIT];
  assign busy        = (state_ff != IRS_IDLE);

  irs_baud u_baud (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_ce     (i_ce),
    .i_load   (brg_load),
    .i_run    (brg_run),
    .i_reload (i_baud_reload_value),
    .o_tmo    (tmo)
  );

  // collisions while the restart owns the bus
  always_comb begin
    bcol_hit = 1'b0;
    if (state_ff == IRS_SCL_RISE || state_ff == IRS_SETUP) begin
      if (scl_rise && !sync_ff.sda) begin
        bcol_hit = 1'b1;
      end
    end
    if (state_ff == IRS_SETUP && !sync_ff.scl) begin
      bcol_hit = 1'b1;
    end
  end

  // next state and baud counter steering
  always_comb begin
    nxt_state = state_ff;
    brg_load  = 1'b0;
    brg_run   = 1'b0;
    if (bcol_hit) begin
      nxt_state = IRS_IDLE;
    end else begin
      unique case (state_ff)
        IRS_IDLE: begin
          if (restart_bit) begin
            nxt_state = IRS_SCL_LOW;
          end
        end
        IRS_SCL_LOW: begin
          if (!sync_ff.scl) begin
            brg_load  = 1'b1;
            nxt_state = IRS_SDA_HIGH;
          end
        end
        IRS_SDA_HIGH: begin
          brg_run = 1'b1;
          if (tmo && sync_ff.sda) begin
            nxt_state = IRS_SCL_RISE;
          end
        end
        IRS_SCL_RISE: begin
          // counter frozen while a slave holds the clock low
          if (sync_ff.scl) begin
            brg_load  = 1'b1;
            nxt_state = IRS_SETUP;
          end
        end
        IRS_SETUP: begin
          brg_run = 1'b1;
          if (tmo) begin
            brg_load  = 1'b1;
            nxt_state = IRS_SDA_LOW;
          end
        end
        IRS_SDA_LOW: begin
          brg_run = 1'b1;
          if (tmo) begin
            nxt_state = IRS_HOLD;
          end
        end
        IRS_HOLD: begin
          // no reload here: the flag waits a whole wrap of the counter
          brg_run = 1'b1;
          if (tmo) begin
            nxt_state = IRS_IDLE;
          end
        end
      endcase
    end
  end

  // state register, one step per enabled clock
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= IRS_IDLE;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // -------------------------------------------------------------
  // pin drive
  // -------------------------------------------------------------
  // open drain: output always low, enable means pulling the line
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
    end else if (i_ce) begin
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
      o_scl_oe <= (nxt_state == IRS_SCL_LOW) ||
                  (nxt_state == IRS_SDA_HIGH);
      o_sda_oe <= (nxt_state == IRS_SDA_LOW) ||
                  (nxt_state == IRS_HOLD);
    end
  end

  // -------------------------------------------------------------
  // control word
  // -------------------------------------------------------------
  // the self-clear drops only the request bit; writes stay blocked until the hold ends and the state is idle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_serial_port_control_2 <= `IRS_CTL2_RST;
    end else if (i_ce) begin
      if ((state_ff == IRS_SDA_LOW && tmo) || bcol_hit) begin
        o_serial_port_control_2[`IRS_CTL2_RESTART_BIT] <= 1'b0;
      end else if (i_ctl2_we && !busy) begin
        o_serial_port_control_2 <= i_ctl2_wdata;
        if (i_other_busy) begin
          o_serial_port_control_2[`IRS_CTL2_RESTART_BIT] <= 1'b0;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // shift buffer and flags
  // -------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_shift_buffer <= `IRS_BUF_RST;
    end else if (i_ce && i_buf_we && !busy) begin
      o_shift_buffer <= i_buf_wdata;
    end
  end

  // sticky flags: a set in the clear cycle wins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_write_collision_flag <= 1'b0;
      o_bus_collision_flag   <= 1'b0;
      o_port_event_flag      <= 1'b0;
      o_start_seen           <= 1'b0;
    end else if (i_ce) begin
      if (i_buf_we && busy) begin
        o_write_collision_flag <= 1'b1;
      end else if (i_write_collision_flag_clr) begin
        o_write_collision_flag <= 1'b0;
      end
      if (bcol_hit) begin
        o_bus_collision_flag <= 1'b1;
      end else if (i_bcol_clr) begin
        o_bus_collision_flag <= 1'b0;
      end
      if (state_ff == IRS_HOLD && tmo) begin
        o_port_event_flag <= 1'b1;
      end else if (i_evt_clr) begin
        o_port_event_flag <= 1'b0;
      end
      // status bit follows the last start seen on the lines
      if (start_cond) begin
        o_start_seen <= 1'b1;
      end else if (i_ctl2_we && !busy) begin
        o_start_seen <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_sda_low_tmo;
    state_ff == IRS_SDA_LOW && tmo && !bcol_hit && i_ce;
  endsequence

  AST_FREEZE: assert property (
    i_ce && state_ff == IRS_SCL_RISE && !sync_ff.scl |=> !tmo)
    else $error("counter ran while clock released low");
  AST_RELOAD: assert property (
    i_ce && state_ff == IRS_SCL_RISE && sync_ff.scl && !bcol_hit
    |=> state_ff == IRS_SETUP)
    else $error("no reload on clock high");
  AST_START_IDLE: assert property (
    state_ff == IRS_IDLE && !restart_bit |=> state_ff == IRS_IDLE)
    else $error("restart without request");
  AST_SCL_PULL: assert property (
    i_ce && state_ff == IRS_IDLE && restart_bit |=> o_scl_oe)
    else $error("clock not pulled low on restart");
  AST_SDA_LOW_STEP: assert property (
    i_ce && state_ff == IRS_SETUP && tmo && !bcol_hit |=> o_sda_oe)
    else $error("data not driven low after setup");
  AST_SELF_CLEAR: assert property (
    s_sda_low_tmo |=> !restart_bit && o_sda_oe)
    else $error("request bit not cleared");
  AST_EVT: assert property (
    $rose(o_port_event_flag) |-> $past(state_ff) == IRS_HOLD)
    else $error("event flag raised early");
  AST_BUSY_WR: assert property (
    i_ce && i_ctl2_we && i_other_busy && !busy |=> !restart_bit)
    else $error("request taken while bus busy");
  AST_WRITE_COLLISION_FLAG: assert property (
    i_ce && i_buf_we && busy |=> o_write_collision_flag &&
    $stable(o_shift_buffer))
    else $error("buffer write not blocked");
  AST_BCOL: assert property (
    i_ce && state_ff == IRS_SETUP && !sync_ff.scl
    |=> o_bus_collision_flag && state_ff == IRS_IDLE)
    else $error("missed clock-low collision");

  // steps of the restart walk, used by the checks below
  sequence s_setup_go;
    state_ff == IRS_SDA_HIGH && tmo && sync_ff.sda && i_ce;
  endsequence

  sequence s_rise_on_low_data;
    (state_ff == IRS_SCL_RISE || state_ff == IRS_SETUP) && i_ce &&
    scl_rise && !sync_ff.sda;
  endsequence

  AST_SCL_LOAD: assert property (
    i_ce && state_ff == IRS_SCL_LOW && !sync_ff.scl
    |=> state_ff == IRS_SDA_HIGH && o_scl_oe)
    else $error("counter not started once clock read low");
  AST_SDA_FREE: assert property (
    state_ff == IRS_SDA_HIGH |-> o_scl_oe && !o_sda_oe)
    else $error("data not released while clock held low");
  AST_SCL_FREE: assert property (
    s_setup_go |=> !o_scl_oe && state_ff == IRS_SCL_RISE)
    else $error("clock not released after timeout");
  AST_SETUP_HIGH: assert property (
    state_ff == IRS_SETUP |-> !o_sda_oe && !o_scl_oe)
    else $error("lines not both released during setup");
  AST_HOLD_LOW: assert property (
    state_ff == IRS_HOLD |-> o_sda_oe && !o_scl_oe)
    else $error("data not held low after start");
  AST_START_SEEN: assert property (
    i_ce && start_cond |=> o_start_seen)
    else $error("start on the lines not flagged");
  AST_BCOL_RISE: assert property (
    s_rise_on_low_data |=> o_bus_collision_flag && !restart_bit)
    else $error("missed low data on clock rise");
  AST_CTL_HOLD: assert property (
    i_ce && busy && !bcol_hit && !(state_ff == IRS_SDA_LOW && tmo)
    |=> $stable(o_serial_port_control_2))
    else $error("control bits changed during restart");
  // a low enable must stop the counter along with the sequencer
  AST_CE_FREEZE: assert property (
    !i_ce |=> $stable(state_ff) && $stable(u_baud.cnt_ff))
    else $error("state moved while clock enable low");
endmodule

//--- hw/irs_map.svh
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH
// field positions within the control word
`define IRS_CTL2_RESTART_BIT 1
`define IRS_CTL2_LOW_W 5
`define IRS_STAT_START_BIT 3
// widths
`define IRS_RELOAD_W 7
`define IRS_DATA_W 8
// reset values
`define IRS_RELOAD_RST 7'h00
`define IRS_BUF_RST 8'h00
`define IRS_CTL2_RST 5'h00
// count step
`define IRS_CNT_ZERO 7'h00
`define IRS_CNT_ONE 7'h01
`endif

//--- hw/irs_pkg.sv
`include "irs_map.svh"
package irs_pkg;
  // both bus lines seen from inside: sampled clock and data levels
  typedef struct packed {
    logic scl;
    logic sda;
  } irs_lines_t;

  // event pulses reported to the core
  typedef struct packed {
    logic start_seen;
    logic done;
    logic write_collision_flag;
    logic bcol;
  } irs_events_t;

  typedef enum logic [2:0] {
    IRS_IDLE,
    IRS_SCL_LOW,
    IRS_SDA_HIGH,
    IRS_SCL_RISE,
    IRS_SETUP,
    IRS_SDA_LOW,
    IRS_HOLD
  } irs_state_t;
endpackage

//--- hw/irs_baud.sv
`timescale 1ns/100ps
`include "irs_map.svh"
module irs_baud (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_ce,
  input  wire logic                       i_load,
  input  wire logic                       i_run,
  input  wire logic [`IRS_RELOAD_W-1:0]   i_reload,
  output logic                            o_tmo
);
  logic [`IRS_RELOAD_W-1:0] cnt_ff;

  // -------------------------------------------------------------
  // down counter, timeout on rollover
  // -------------------------------------------------------------
  // load wins over counting; a stopped counter holds its value
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_ff <= `IRS_CNT_ZERO;
    end else if (i_ce) begin
      if (i_load) begin
        cnt_ff <= i_reload;
      end else if (i_run) begin
        cnt_ff <= cnt_ff - `IRS_CNT_ONE;
      end
    end
  end

  // pulse when the count passes zero and wraps
  // held while frozen, so the sequencer still sees it once enabled
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_tmo <= 1'b0;
    end else if (i_ce) begin
      o_tmo <= i_run && !i_load && (cnt_ff == `IRS_CNT_ZERO);
    end
  end
endmodule

//--- dv/irs_bus_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// far side: slave that may stretch the clock, master that may jam
// ----------------------------------------------------------------
module irs_bus_model (
  input  wire logic       i_clk,
  input  wire logic       i_scl_oe,
  input  wire logic       i_sda_oe,
  input  wire logic [4:0] i_stretch,
  input  wire logic       i_sda_jam,
  input  wire logic       i_scl_jam,
  output logic            o_scl,
  output logic            o_sda
);
  logic [4:0] hold_ff = 5'h0;

  // preload while the master pulls low, so no glitch high on release
  always_ff @(posedge i_clk) begin
    if (i_scl_oe) begin
      hold_ff <= i_stretch;
    end else if (hold_ff != 5'h0) begin
      hold_ff <= hold_ff - 5'h1;
    end
  end

  // wired-and with pull-ups: any party driving wins low
  assign o_scl = !(i_scl_oe || (hold_ff != 5'h0) || i_scl_jam);
  assign o_sda = !(i_sda_oe || i_sda_jam);
endmodule

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import irs_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk = 1'b0, rst = 1'b1, other = 1'b0, jam = 1'b0;
  logic [6:0] rl = 7'h00;
  logic [4:0] st = 5'h0, cwd = 5'h00, ctl2;
  logic       cwe = 1'b0, bwe = 1'b0, eclr = 1'b0, wclr = 1'b0;
  logic       bclr = 1'b0;
  logic       ce = 1'b1, sjam = 1'b0;
  logic [7:0] bwd = 8'h00, sbuf, bexp;
  logic       scl, sda, scl_oe, sda_oe, scl_o, sda_o;
  logic       ss, evt, write_collision_flag, bcol;
  int         bad_count = 0, comparisons = 0, seed = 98, cyc = 0;
  int         n, hi, lo, sbad;

  always #12.5 clk = ~clk;

  irs_restart dut (.i_clk(clk), .i_reset(rst), .i_ce(ce),
    .i_scl(scl), .i_sda(sda), .i_other_busy(other),
    .i_baud_reload_value(rl), .i_ctl2_we(cwe), .i_ctl2_wdata(cwd),
    .i_buf_we(bwe), .i_buf_wdata(bwd), .i_evt_clr(eclr),
    .i_write_collision_flag_clr(wclr), .i_bcol_clr(bclr), .o_scl_o(scl_o),
    .o_scl_oe(scl_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .o_serial_port_control_2(ctl2), .o_start_seen(ss),
    .o_port_event_flag(evt), .o_write_collision_flag(write_collision_flag),
    .o_bus_collision_flag(bcol), .o_shift_buffer(sbuf));

  irs_bus_model far (.i_clk(clk), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe),
    .i_stretch(st), .i_sda_jam(jam), .i_scl_jam(sjam), .o_scl(scl),
    .o_sda(sda));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int bper(logic [6:0] r);
    return int'(r) + 1; // one baud period in clocks
  endfunction

  // no reload after the start, so the flag waits a full counter wrap
  function automatic int hold_len();
    return 1 << 7;
  endfunction

  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one-cycle pulse of a control write, taken at the second edge
  task automatic ctl_write(logic [4:0] d);
    @(posedge clk); cwe <= 1'b1; cwd <= d;
    @(posedge clk); cwe <= 1'b0;
  endtask

  // cut a hang short; a full pass needs well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      results();
    end
  end

  // full restart with timing measured on the lines
  task automatic restart(logic [6:0] r, logic [4:0] s);
    @(posedge clk); rl <= r; st <= s;
    ctl_write(5'h02);
    #1 check("restart_bit", 8'h01, 8'(ctl2[1]));
    n = 0;
    while (scl_oe !== 1'b1 && n < 4) begin @(posedge clk); #1 n++; end
    check("scl_pulled", 8'h01, 8'(scl_oe));
    // writes during the sequence must bounce
    @(posedge clk); bwe <= 1'b1; bwd <= ~bexp; cwe <= 1'b1; cwd <= 5'h00;
    @(posedge clk); bwe <= 1'b0; cwe <= 1'b0;
    #1 check("write_collision_flag", 8'h01, 8'(write_collision_flag));
    check("buffer_kept", bexp, sbuf);
    check("ctl2_blocked", 8'h01, 8'(ctl2[1]));
    hi = 0; n = 0;
    while (sda_oe !== 1'b1 && n < 600) begin
      @(posedge clk); #1 n++;
      if (sda_oe !== 1'b1)
        hi = (scl === 1'b1 && sda === 1'b1) ? hi + 1 : 0;
    end
    check("setup_min", 8'h01, 8'(hi >= bper(r)));
    check("setup_max", 8'h01, 8'(hi <= bper(r) + 6));
    lo = 0; sbad = 0;
    while (ctl2[1] !== 1'b0 && lo < 600) begin
      @(posedge clk); #1 lo++;
      if (scl !== 1'b1) sbad++;
    end
    check("sda_low_min", 8'h01, 8'(lo >= bper(r)));
    check("sda_low_max", 8'h01, 8'(lo <= bper(r) + 6));
    check("sda_held", 8'h01, 8'(sda_oe));
    check("evt_early", 8'h00, 8'(evt));
    n = 0;
    while (evt !== 1'b1 && n < 600) begin
      @(posedge clk); #1 n++;
      if (scl !== 1'b1) sbad++;
    end
    check("hold_min", 8'h01, 8'(n >= hold_len()));
    check("hold_max", 8'h01, 8'(n <= hold_len() + 2));
    check("scl_high", 8'h00, 8'(sbad));
    check("start_seen", 8'h01, 8'(ss));
    check("bit_cleared", 8'h00, 8'(ctl2[1]));
    @(posedge clk); eclr <= 1'b1; wclr <= 1'b1;
    @(posedge clk); eclr <= 1'b0; wclr <= 1'b0;
    #1 check("flags_clr", 8'h00, {6'h00, evt, write_collision_flag});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 check("reset_out", 8'h00, {scl_oe, sda_oe, scl_o, sda_o,
      ss, evt, write_collision_flag, bcol});
    check("reset_buf", 8'h00, sbuf);
    for (int i = 0; i < 6; i++) begin
      bexp = 8'($random(seed));
      @(posedge clk); bwe <= 1'b1; bwd <= bexp;
      @(posedge clk); bwe <= 1'b0;
      #1 check("buf_write", bexp, sbuf);
      case (i)
        0: restart(7'h00, 5'h00);
        1: restart(7'h7f, 5'h1f);
        default: restart(7'($random(seed)) & 7'h0f, 5'($random(seed)));
      endcase
    end
    // request while another event runs is dropped
    @(posedge clk); other <= 1'b1;
    ctl_write(5'h02);
    n = 0;
    repeat (10) begin @(posedge clk); #1 if (scl_oe !== 1'b0) n++; end
    check("busy_drop", 8'h00, 8'(n));
    check("busy_bit", 8'h00, 8'(ctl2[1]));
    @(posedge clk); other <= 1'b0; rl <= 7'h03; st <= 5'h08;
    // rival holds data low while a slave stretches the released clock
    ctl_write(5'h02);
    n = 0;
    while (scl_oe !== 1'b1 && n < 20) begin @(posedge clk); #1 n++; end
    while (scl_oe !== 1'b0 && n < 200) begin @(posedge clk); #1 n++; end
    @(posedge clk); jam <= 1'b1;
    n = 0;
    while (bcol !== 1'b1 && n < 200) begin @(posedge clk); #1 n++; end
    check("bcol_set", 8'h01, 8'(bcol));
    check("bcol_abort", 8'h00, 8'(ctl2[1]));
    @(posedge clk); jam <= 1'b0; bclr <= 1'b1;
    @(posedge clk); bclr <= 1'b0;
    #1 check("bcol_clr", 8'h00, 8'(bcol));
    // rival pulls the clock low in the setup before our start edge
    @(posedge clk); rl <= 7'h7f; st <= 5'h00;
    ctl_write(5'h02);
    n = 0;
    while (scl_oe !== 1'b1 && n < 20) begin @(posedge clk); #1 n++; end
    while (scl_oe !== 1'b0 && n < 400) begin @(posedge clk); #1 n++; end
    repeat (8) @(posedge clk);
    sjam <= 1'b1;
    n = 0;
    while (bcol !== 1'b1 && n < 50) begin @(posedge clk); #1 n++; end
    check("bcol_scl", 8'h01, 8'(bcol));
    check("bcol_no_start", 8'h00, 8'(sda_oe));
    check("bcol_scl_bit", 8'h00, 8'(ctl2[1]));
    @(posedge clk); sjam <= 1'b0; bclr <= 1'b1;
    @(posedge clk); bclr <= 1'b0;
    // frozen enable: a buffer write must not land
    @(posedge clk); ce <= 1'b0; bwe <= 1'b1; bwd <= ~bexp;
    @(posedge clk); bwe <= 1'b0; ce <= 1'b1;
    #1 check("ce_freeze", bexp, sbuf);
    results();
  end
endmodule
